//--- drum_xfer_consts.vh
// constants for the drum block transfer control
// assumes an 18-bit processor word, bit 0 of the accumulator is its MSB
//
// What this block does
// - drum words are 18 data bits plus generated parity; core sees 18 bits.
// - transfers move whole 256-word blocks, one block per sector.
// - two sectors per track; 64, 128 or 256 tracks; software addresses sectors.
// - each word moves over the data channel, requested by this control.
// - a faultless block end sets the done flag, which requests an interrupt.
// - 16-bit core address counter increments after every word transfer.
// - 9-bit sector register increments only after a successful block.
// - an 18-bit staging buffer holds words between memory and serial buffer.
// - a 19-bit serial buffer assembles read words and shifts write words.
// - a parity mismatch on a read word sets the error flag.
// - a word request not granted within one word period sets the error flag.
// - code 706006 loads address counter from accumulator 2-17, arms read.
// - code 706046 loads address counter likewise, arms write.
// - code 706106 loads sector from accumulator 9-17, clears flags, starts.
// - code 706204 clears flags and starts with present address and sector.
// - code 706101 skips when the done flag is set.
// - code 706201 skips when the error flag is clear.
// - code 706102 clears both flags.
`ifndef DRUM_XFER_CONSTS_VH
`define DRUM_XFER_CONSTS_VH

// ----------------------------------------
// transfer instruction codes
// ----------------------------------------
`define IOT_LOAD_READ 18'h38C06
`define IOT_LOAD_WRITE 18'h38C26
`define IOT_SECTOR_START 18'h38C46
`define IOT_CONTINUE 18'h38C84
`define IOT_SKIP_DONE 18'h38C41
`define IOT_SKIP_NOERR 18'h38C81
`define IOT_CLEAR_FLAGS 18'h38C42

// ----------------------------------------
// geometry and timing
// ----------------------------------------
`define DATA_BITS 18
`define WORD_BITS 19
`define BLOCK_WORDS 256
`define TRACKS_DEFAULT 256
`define CLK_NS 40
`define DRUM_BIT_NS 4000
`define BIT_CYCLES (`DRUM_BIT_NS / `CLK_NS)
`define WORD_CYCLES (`BIT_CYCLES * `WORD_BITS)

`endif

//--- drum_xfer.v
// drum block transfer control: instruction decode, data channel, serializer
// assumes pulse-wide instruction strobes and a channel granting one word each
`include "drum_xfer_consts.vh"
`default_nettype none

module drum_xfer #(
   parameter TRACKS = `TRACKS_DEFAULT,
   parameter BIT_CYCLES = `BIT_CYCLES,
   parameter WORD_CYCLES = `WORD_CYCLES,
   parameter DEPTH = 2
) (
   input wire clk,
   input wire rst,
   input wire iot_pulse,
   input wire [17:0] iot_code,
   input wire [17:0] processor_accumulator,
   output reg skip_q,
   output reg irq_q,
   output reg done_flag_q,
   output reg err_flag_q,
   output reg dch_req_q,
   input wire dch_grant,
   output reg dch_to_core_q,
   output reg [15:0] dch_addr_q,
   output reg [17:0] dch_data_q,
   input wire [17:0] memory_buffer,
   output reg [8:0] sector_q,
   output reg busy_q,
   input wire drum_rd_bit,
   output reg drum_wr_bit_q,
   output reg drum_wr_en_q
);

   // ----------------------------------------
   // decode
   // ----------------------------------------
   function is_code;
      input pulse;
      input [17:0] code;
      input [17:0] want;
      begin
         is_code = pulse & (code == want);
      end
   endfunction

   localparam ST_IDLE = 2'b00;
   localparam ST_RUN = 2'b01;
   localparam ST_END = 2'b10;

   wire do_ld_rd = is_code(iot_pulse, iot_code, `IOT_LOAD_READ);
   wire do_ld_wr = is_code(iot_pulse, iot_code, `IOT_LOAD_WRITE);
   wire do_sel = is_code(iot_pulse, iot_code, `IOT_SECTOR_START);
   wire do_cont = is_code(iot_pulse, iot_code, `IOT_CONTINUE);
   wire do_sk_done = is_code(iot_pulse, iot_code, `IOT_SKIP_DONE);
   wire do_sk_ok = is_code(iot_pulse, iot_code, `IOT_SKIP_NOERR);
   wire do_clr = is_code(iot_pulse, iot_code, `IOT_CLEAR_FLAGS);

   reg [1:0] state_q;
   reg write_mode_q;
   reg [8:0] ser_cnt_q;
   reg [8:0] xfer_cnt_q;
   reg [15:0] tick_cnt_q;
   reg [4:0] bit_cnt_q;
   reg [18:0] shift_q;
   reg ser_go_q;
   reg [15:0] age_q;
   reg s1_q;
   reg s2_q;
   reg s3_q;
   reg rd_bit_q;

   wire running = (state_q == ST_RUN);
   // a start pulse mid-block would wipe the datapath, so only idle takes it
   wire start = (do_sel | do_cont) & (state_q == ST_IDLE);
   localparam [8:0] SECT_MASK = 2 * TRACKS - 1;
   wire tick = running & ser_go_q & (tick_cnt_q == BIT_CYCLES - 1);
   wire word_edge = tick & (bit_cnt_q == `WORD_BITS - 1);
   wire ser_more = (ser_cnt_q != `BLOCK_WORDS);
   wire xfer_more = (xfer_cnt_q != `BLOCK_WORDS);
   wire grant = dch_req_q & dch_grant;

   // ----------------------------------------
   // two-entry staging buffer
   // ----------------------------------------
   // staging buffer
   reg [17:0] word_staging_buffer [0:DEPTH-1];
   reg [0:0] rd_ptr_q;
   reg [0:0] wr_ptr_q;
   reg [1:0] count_q;
   wire buf_valid = (count_q != 2'h0);
   wire buf_ready = (count_q != DEPTH);
   wire [17:0] buf_head = word_staging_buffer[rd_ptr_q];
   reg push_valid;
   reg [17:0] push_data;
   reg pop_ready;
   wire push = push_valid & buf_ready;
   wire pop = pop_ready & buf_valid;

   always @(posedge clk)
   begin
      if (rst | start)
      begin
         rd_ptr_q <= 1'b0;
         wr_ptr_q <= 1'b0;
         count_q <= 2'h0;
      end
      else
      begin
         if (push)
         begin
            word_staging_buffer[wr_ptr_q] <= push_data;
            wr_ptr_q <= wr_ptr_q + 1'b1;
         end
         if (pop)
            rd_ptr_q <= rd_ptr_q + 1'b1;
         count_q <= count_q + {1'b0, push} - {1'b0, pop};
      end
   end

   // ----------------------------------------
   // read data arrival
   // ----------------------------------------
   // read word, parity check
   wire [18:0] rd_word = {shift_q[17:0], rd_bit_q};
   wire rd_par_bad = ~(^rd_word);

   always @*
   begin
      push_valid = 1'b0;
      push_data = 18'h00000;
      pop_ready = 1'b0;
      if (running)
      begin
         if (write_mode_q)
         begin
            push_valid = grant;
            push_data = memory_buffer;
            pop_ready = tick & (bit_cnt_q == 5'h00) & ser_more;
         end
         else
         begin
            push_valid = word_edge & ser_more;
            push_data = rd_word[18:1];
            pop_ready = grant;
         end
      end
   end

   // ----------------------------------------
   // pin synchroniser
   // ----------------------------------------
   always @(posedge clk)
   begin
      if (rst)
      begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
         rd_bit_q <= 1'b0;
      end
      else
      begin
         s1_q <= drum_rd_bit;
         s2_q <= s1_q;
         s3_q <= s2_q;
         if (s2_q == s3_q)
            rd_bit_q <= s3_q;
      end
   end

   // ----------------------------------------
   // main control
   // ----------------------------------------
   reg err_set;
   reg done_set;
   reg [1:0] state_d;
   always @*
   begin
      err_set = 1'b0;
      done_set = 1'b0;
      state_d = state_q;
      case (state_q)
         ST_IDLE:
            if (start)
               state_d = ST_RUN;
         ST_RUN:
         begin
            if (!write_mode_q & word_edge & ser_more & rd_par_bad)
               err_set = 1'b1;
            if (push_valid & !buf_ready)
               err_set = 1'b1;
            if (pop_ready & !buf_valid)
               err_set = 1'b1;
            if (dch_req_q & !dch_grant & (age_q == WORD_CYCLES - 1))
               err_set = 1'b1;
            if (!ser_more & !xfer_more)
               state_d = ST_END;
         end
         ST_END:
         begin
            done_set = ~err_flag_q;
            state_d = ST_IDLE;
         end
         default:
            state_d = ST_IDLE;
      endcase
   end

   always @(posedge clk)
   begin
      if (rst)
      begin
         state_q <= ST_IDLE;
         write_mode_q <= 1'b0;
         done_flag_q <= 1'b0;
         err_flag_q <= 1'b0;
         irq_q <= 1'b0;
         skip_q <= 1'b0;
         sector_q <= 9'h000;
         busy_q <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
         busy_q <= (state_d != ST_IDLE);
         if (do_ld_rd & !running)
            write_mode_q <= 1'b0;
         if (do_ld_wr & !running)
            write_mode_q <= 1'b1;
         // sector load, wraps at drum size
         if (do_sel & !running)
            sector_q <= processor_accumulator[8:0] & SECT_MASK;
         if (done_set)
            sector_q <= (sector_q + 9'h001) & SECT_MASK;
         if (err_set)
            err_flag_q <= 1'b1;
         else if (start | do_clr)
            err_flag_q <= 1'b0;
         if (done_set)
            done_flag_q <= 1'b1;
         else if (start | do_clr)
            done_flag_q <= 1'b0;
         irq_q <= done_set | (done_flag_q & ~(start | do_clr));
         skip_q <= (do_sk_done & done_flag_q) | (do_sk_ok & ~err_flag_q);
      end
   end

   // ----------------------------------------
   // data channel
   // ----------------------------------------
   always @(posedge clk)
   begin
      if (rst)
      begin
         dch_req_q <= 1'b0;
         dch_to_core_q <= 1'b0;
         dch_addr_q <= 16'h0000;
         dch_data_q <= 18'h00000;
         xfer_cnt_q <= 9'h000;
         age_q <= 16'h0000;
      end
      else
      begin
         if ((do_ld_rd | do_ld_wr) & !running)
            dch_addr_q <= processor_accumulator[15:0];
         if (start)
         begin
            xfer_cnt_q <= 9'h000;
            dch_req_q <= 1'b0;
            dch_to_core_q <= ~write_mode_q;
         end
         else if (running)
         begin
            if (grant)
            begin
               dch_req_q <= 1'b0;
               dch_addr_q <= dch_addr_q + 16'h0001;
               xfer_cnt_q <= xfer_cnt_q + 9'h001;
            end
            else if (!dch_req_q & xfer_more)
            begin
               if (write_mode_q & buf_ready & !ser_go_q)
                  dch_req_q <= 1'b1;
               else if (write_mode_q & (count_q == 2'h1) & !pop)
                  dch_req_q <= 1'b1;
               else if (!write_mode_q & buf_valid)
               begin
                  dch_req_q <= 1'b1;
                  dch_data_q <= buf_head;
               end
            end
         end
         else
            dch_req_q <= 1'b0;
         if (dch_req_q & !dch_grant & (age_q != WORD_CYCLES - 1))
            age_q <= age_q + 16'h0001;
         else if (!dch_req_q | grant)
            age_q <= 16'h0000;
      end
   end

   // ----------------------------------------
   // serial shift buffer
   // ----------------------------------------
   // serial shift buffer
   always @(posedge clk)
   begin
      if (rst | start)
      begin
         tick_cnt_q <= 16'h0000;
         bit_cnt_q <= 5'h00;
         shift_q <= 19'h00000;
         ser_cnt_q <= 9'h000;
         ser_go_q <= 1'b0;
         drum_wr_bit_q <= 1'b0;
         drum_wr_en_q <= 1'b0;
      end
      else if (running)
      begin
         // writing waits for a full buffer so a slow grant costs no word
         if (!write_mode_q | (count_q == DEPTH) | !xfer_more)
            ser_go_q <= 1'b1;
         if (ser_go_q)
            tick_cnt_q <= (tick_cnt_q == BIT_CYCLES - 1) ? 16'h0000 :
                          tick_cnt_q + 16'h0001;
         if (tick & ser_more)
         begin
            bit_cnt_q <= word_edge ? 5'h00 : bit_cnt_q + 5'h01;
            if (word_edge)
               ser_cnt_q <= ser_cnt_q + 9'h001;
            if (write_mode_q)
            begin
               drum_wr_en_q <= 1'b1;
               if (bit_cnt_q == 5'h00)
               begin
                  shift_q <= {buf_head[16:0], ~(^buf_head), 1'b0};
                  drum_wr_bit_q <= buf_valid ? buf_head[17] : 1'b0;
               end
               else
               begin
                  shift_q <= {shift_q[17:0], 1'b0};
                  drum_wr_bit_q <= shift_q[18];
               end
            end
            else
               shift_q <= word_edge ? 19'h00000 :
                          {shift_q[17:0], rd_bit_q};
         end
         else if (tick)
            drum_wr_en_q <= 1'b0;
      end
      else
         drum_wr_en_q <= 1'b0;
   end

endmodule

`default_nettype wire

//--- drum_xfer_chk.sv
// checker: port-level assertions for the drum block transfer control
// assumes one clock and a synchronous active-high reset
`include "drum_xfer_consts.vh"
`default_nettype none
module drum_xfer_chk #(
   parameter int WORD_CYCLES = 76
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic iot_pulse,
   input wire logic [17:0] iot_code,
   input wire logic [17:0] processor_accumulator,
   input wire logic skip_q,
   input wire logic irq_q,
   input wire logic done_flag_q,
   input wire logic err_flag_q,
   input wire logic dch_req_q,
   input wire logic dch_grant,
   input wire logic [15:0] dch_addr_q,
   input wire logic [17:0] dch_data_q,
   input wire logic [8:0] sector_q,
   input wire logic busy_q
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] wait_q;
   default clocking @(posedge clk);
   endclocking
   default disable iff (rst);
   // ----------------------------------------
   // request age, too long for a repetition
   // ----------------------------------------
   always @(posedge clk)
   begin
      if (rst || !dch_req_q || dch_grant)
         wait_q <= 16'h0;
      else
         wait_q <= wait_q + 16'h1;
   end
   // ----------------------------------------
   // properties
   // ----------------------------------------
   property p_skip_done;
      iot_pulse && iot_code == `IOT_SKIP_DONE |=> skip_q == $past(done_flag_q);
   endproperty
   a_skip_done: assert property (p_skip_done) else $error("skip on done");
   property p_skip_noerr;
      iot_pulse && iot_code == `IOT_SKIP_NOERR |=> skip_q == !$past(err_flag_q);
   endproperty
   a_skip_noerr: assert property (p_skip_noerr) else $error("skip no err");
   property p_skip_cause;
      skip_q |-> $past(iot_pulse) && ($past(iot_code) == `IOT_SKIP_DONE ||
         $past(iot_code) == `IOT_SKIP_NOERR);
   endproperty
   a_skip_cause: assert property (p_skip_cause) else $error("stray skip");
   property p_load;
      iot_pulse && !busy_q && (iot_code == `IOT_LOAD_READ ||
         iot_code == `IOT_LOAD_WRITE) |=>
         dch_addr_q == 16'($past(processor_accumulator));
   endproperty
   a_load: assert property (p_load) else $error("address load");
   property p_start;
      iot_pulse && !busy_q && iot_code == `IOT_SECTOR_START |=> busy_q &&
         !done_flag_q && sector_q == 9'($past(processor_accumulator));
   endproperty
   a_start: assert property (p_start) else $error("sector start");
   property p_clear;
      iot_pulse && !busy_q && (iot_code == `IOT_CLEAR_FLAGS ||
         iot_code == `IOT_CONTINUE) |=> !done_flag_q && !err_flag_q;
   endproperty
   a_clear: assert property (p_clear) else $error("flag clear");
   property p_done;
      $rose(done_flag_q) |-> (!busy_q && !err_flag_q) ##[0:1] irq_q;
   endproperty
   a_done: assert property (p_done) else $error("done flag");
   property p_sector;
      $changed(sector_q) && !$past(iot_pulse) && !$past(rst) |->
         sector_q == 9'($past(sector_q) + 9'h1) && done_flag_q;
   endproperty
   a_sector: assert property (p_sector) else $error("sector step");
   property p_addr_inc;
      dch_req_q && dch_grant |=> dch_addr_q == $past(dch_addr_q) + 16'h1;
   endproperty
   a_addr_inc: assert property (p_addr_inc) else $error("addr step");
   property p_req_hold;
      dch_req_q && !dch_grant |=> dch_req_q && $stable(dch_data_q) &&
         $stable(dch_addr_q);
   endproperty
   a_req_hold: assert property (p_req_hold) else $error("req hold");
   property p_late;
      wait_q == WORD_CYCLES |-> ##[0:3] err_flag_q;
   endproperty
   a_late: assert property (p_late) else $error("late grant");
endmodule
bind drum_xfer drum_xfer_chk #(.WORD_CYCLES(WORD_CYCLES)) drum_xfer_chk_i (
   .clk(clk), .rst(rst), .iot_pulse(iot_pulse), .iot_code(iot_code),
   .processor_accumulator(processor_accumulator), .skip_q(skip_q),
   .irq_q(irq_q), .done_flag_q(done_flag_q), .err_flag_q(err_flag_q),
   .dch_req_q(dch_req_q), .dch_grant(dch_grant), .dch_addr_q(dch_addr_q),
   .dch_data_q(dch_data_q), .sector_q(sector_q), .busy_q(busy_q));
`default_nettype wire

//--- dch_model.sv
// model of the processor data channel granting drum word requests
// assumes requests stay up until granted; delay comes from the bench
`default_nettype none
module dch_model (
   input wire logic clk,
   input wire logic rst,
   input wire logic dch_req_q,
   input wire logic [15:0] dch_addr_q,
   input wire logic [7:0] delay,
   output var logic dch_grant,
   output wire logic [17:0] memory_buffer
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] wait_q;
   always @(posedge clk)
   begin
      if (rst || !dch_req_q || dch_grant)
      begin
         wait_q <= 8'h0;
         dch_grant <= 1'b0;
      end
      else
      begin
         wait_q <= wait_q + 8'h1;
         dch_grant <= wait_q >= delay;
      end
   end
   // bus shows junk outside a grant so stale words are not mistaken
   assign memory_buffer = dch_grant ? {2'h1, dch_addr_q} :
      {2'h2, ~dch_addr_q ^ {8'h0, wait_q}};
endmodule
`default_nettype wire

//--- drum_xfer_test.sv
// testbench: drives instructions and drum data, checks channel words
// assumes the channel model above and a shortened bit period
`include "drum_xfer_consts.vh"
`default_nettype none
module drum_xfer_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0, rst = 1'b1, iot_pulse = 1'b0, drum_rd_bit = 1'b0;
   logic [17:0] iot_code = 18'h0, processor_accumulator = 18'h0;
   logic [7:0] delay = 8'h0;
   wire logic skip_q, irq_q, done_flag_q, err_flag_q, dch_req_q, dch_grant;
   wire logic dch_to_core_q, busy_q, drum_wr_bit_q, drum_wr_en_q;
   wire logic [15:0] dch_addr_q;
   wire logic [17:0] dch_data_q, memory_buffer;
   wire logic [8:0] sector_q;
   int error_cnt = 0, tests_run = 0, cyc = 0;
   logic [33:0] exq[$];
   logic [17:0] wq[$];
   logic [18:0] wsr = 19'h0;
   logic [1:0] ph = 2'h0;
   int wb = 0;
   logic [33:0] e;
   logic [15:0] ea;
   logic [8:0] es;
   logic dr;
   always #20 clk = ~clk;
   drum_xfer #(.BIT_CYCLES(4), .WORD_CYCLES(76)) drum_xfer_i (
      .clk(clk), .rst(rst), .iot_pulse(iot_pulse), .iot_code(iot_code),
      .processor_accumulator(processor_accumulator), .skip_q(skip_q),
      .irq_q(irq_q), .done_flag_q(done_flag_q), .err_flag_q(err_flag_q),
      .dch_req_q(dch_req_q), .dch_grant(dch_grant),
      .dch_to_core_q(dch_to_core_q), .dch_addr_q(dch_addr_q),
      .dch_data_q(dch_data_q), .memory_buffer(memory_buffer),
      .sector_q(sector_q), .busy_q(busy_q), .drum_rd_bit(drum_rd_bit),
      .drum_wr_bit_q(drum_wr_bit_q), .drum_wr_en_q(drum_wr_en_q));
   dch_model dch_model_i (.clk(clk), .rst(rst), .dch_req_q(dch_req_q),
      .dch_addr_q(dch_addr_q), .delay(delay), .dch_grant(dch_grant),
      .memory_buffer(memory_buffer));
   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task test_done();
      if (error_cnt == 0 && tests_run > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task chk(input string n, input logic [17:0] ex, input logic [17:0] s);
      tests_run++;
      if (s !== ex)
      begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", n, ex, s);
      end
   endtask
   task iot(input logic [17:0] c, input logic [17:0] a);
      @(negedge clk);
      iot_pulse = 1'b1;
      iot_code = c;
      processor_accumulator = a;
      @(negedge clk);
      iot_pulse = 1'b0;
   endtask
   task sk(input logic [17:0] c, input logic ex);
      iot(c, 18'($urandom));
      chk("skip", ex, skip_q);
   endtask
   // one block: optional load, start, wait, then the end state
   task blk(input logic [17:0] lc, input logic [17:0] acc,
      input logic [17:0] sc, input logic rd, input logic [7:0] dl,
      input logic ee);
      int n;
      drum_rd_bit = rd;
      delay = dl;
      if (lc != 18'h0)
      begin
         iot(lc, acc);
         ea = acc[15:0];
         dr = lc == `IOT_LOAD_READ;
      end
      iot(sc, acc);
      if (sc == `IOT_SECTOR_START)
         es = acc[8:0];
      // constant ones give odd parity, zeros never do, at any framing
      for (n = 0; n < 256; n++)
      begin
         exq.push_back({ea + 16'(n), rd ? 18'h3FFFF : 18'h0});
         if (!dr)
            wq.push_back({2'h1, ea + 16'(n)});
      end
      chk("busy", 1, busy_q);
      chk("dir", dr, dch_to_core_q);
      iot(`IOT_LOAD_WRITE, 18'($urandom));
      for (n = 0; n < 30000 && busy_q; n++)
         @(negedge clk);
      @(negedge clk);
      ea = ea + 16'h100;
      es = ee ? es : es + 9'h1;
      chk("done", !ee, done_flag_q);
      chk("irq", !ee, irq_q);
      chk("err", ee, err_flag_q);
      chk("sector", es, sector_q);
      chk("addr", ea, dch_addr_q);
      chk("left", 0, 18'(exq.size()));
      chk("wleft", 0, 18'(wq.size()));
   endtask
   // ----------------------------------------
   // channel monitor
   // ----------------------------------------
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 100000)
      begin
         error_cnt++;
         test_done();
      end
      // drum write side: one bit per four clocks while the gate is open
      if (!drum_wr_en_q)
      begin
         ph <= 2'h0;
         wb = 0;
      end
      else
      begin
         ph <= ph + 2'h1;
         if (ph == 2'h0)
         begin
            wsr = {wsr[17:0], drum_wr_bit_q};
            wb++;
            if (wb == 19)
            begin
               wb = 0;
               chk("parity", 1, 18'(^wsr));
               if (wq.size() == 0)
                  chk("wextra", 0, 1);
               else
                  chk("wbits", wq.pop_front(), wsr[18:1]);
            end
         end
      end
      if (dch_req_q && dch_grant)
      begin
         delay <= 8'($urandom_range(3));
         if (exq.size() == 0)
            chk("extra", 0, 1);
         else
         begin
            e = exq.pop_front();
            chk("waddr", e[33:18], dch_addr_q);
            if (dch_to_core_q)
               chk("wdata", e[17:0], dch_data_q);
         end
      end
   end
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial
   begin
      void'($urandom(32'h331A0AF2));
      repeat (20) @(negedge clk);
      rst = 1'b0;
      sk(`IOT_SKIP_DONE, 0);
      sk(`IOT_SKIP_NOERR, 1);
      blk(`IOT_LOAD_READ, 18'($urandom), `IOT_SECTOR_START, 1,
         8'($urandom_range(3)), 0);
      sk(`IOT_SKIP_DONE, 1);
      sk(`IOT_SKIP_NOERR, 1);
      iot(`IOT_CLEAR_FLAGS, 18'($urandom));
      chk("clear", 0, {done_flag_q, err_flag_q});
      blk(18'h0, 18'h0, `IOT_CONTINUE, 0, 8'h2, 1);
      sk(`IOT_SKIP_NOERR, 0);
      sk(`IOT_SKIP_DONE, 0);
      blk(`IOT_LOAD_WRITE, {9'($urandom), 9'h1FF}, `IOT_SECTOR_START, 1,
         8'($urandom_range(3)), 0);
      blk(18'h0, 18'h0, `IOT_CONTINUE, 1, 8'd100, 1);
      test_done();
   end
endmodule
`default_nettype wire
